/* File: logic/beamformer_serial_control_port.sv */
`timescale 1ns/1ps
module beamformer_serial_control_port (
   // system clock and reset
   input  wire logic                clk_i,
   input  wire logic                arst_n_i,
   // serial link
   input  wire logic                sclk_i,
   input  wire logic                cs_n_i,
   input  wire logic                sdio_i,
   output logic                     sdio_o,
   output logic                     sdio_oe_o,
   output logic                     serial_data_out_o,
   output logic                     serial_data_out_oe_o,
   // straps and mode pins
   input  wire logic                array_addr_bit0_i,
   input  wire logic                array_addr_bit1_i,
   input  wire logic                array_addr_bit2_i,
   input  wire logic                array_addr_bit3_i,
   input  wire logic                protocol_sel_i,
   input  wire logic                three_wire_i,
   // load strobe
   input  wire logic                load_i,
   // working registers towards the channels
   output logic [15:0][7:0]         tx_work_o,
   output logic [15:0][7:0]         rx_work_o
);

   link_if lk ();

   logic [bfscp_pkg::SY_W-1:0] sy_in_w;
   logic [bfscp_pkg::SY_W-1:0] s1_q, s1_d, s2_q, s2_d;
   logic [3:0]                 straps_w;
   logic                       cs_hi_w;
   logic                       match_w;
   logic                       proto_ok_w;
   logic                       wr_new_w;
   logic                       commit_w;
   logic                       rd_new_w;
   logic                       load_rise_w;
   logic                       wr_txh_w;
   logic [7:0]                 status_w;
   bfscp_pkg::region_t         reg_rg_w;
   logic                       frame_seen_q, frame_seen_d;
   logic                       req_seen_q, req_seen_d;
   logic                       ack_q, ack_d;
   logic [7:0]                 rd_data_q, rd_data_d;
   logic                       load_prev_q, load_prev_d;
   logic [1:0]                 load_cnt_q, load_cnt_d;
   logic [15:0][7:0]           tx_hold_q, tx_hold_d;
   logic [15:0][7:0]           rx_hold_q, rx_hold_d;
   logic [15:0][7:0]           tx_work_q, tx_work_d;
   logic [15:0][7:0]           rx_work_q, rx_work_d;
   logic                       up_q;

   // decode a register address into its region
   function automatic bfscp_pkg::region_t region_of(
      input logic [10:0] a
   );
      bfscp_pkg::region_t r;
      r = bfscp_pkg::RG_NONE;
      if (a[10:4] == bfscp_pkg::TX_HOLD_BASE[10:4]) begin
         r = bfscp_pkg::RG_TXH;
      end else if (a[10:4] == bfscp_pkg::RX_HOLD_BASE[10:4]) begin
         r = bfscp_pkg::RG_RXH;
      end else if (a[10:4] == bfscp_pkg::TX_WORK_BASE[10:4]) begin
         r = bfscp_pkg::RG_TXW;
      end else if (a[10:4] == bfscp_pkg::RX_WORK_BASE[10:4]) begin
         r = bfscp_pkg::RG_RXW;
      end else if (a == bfscp_pkg::STATUS_ADDR) begin
         r = bfscp_pkg::RG_STAT;
      end
      return r;
   endfunction : region_of

   // link-side shift engine on the serial clock
   serial_link_engine u_link (
      .sclk_i               (sclk_i),
      .arst_n_i             (arst_n_i),
      .cs_n_i               (cs_n_i),
      .sdio_i               (sdio_i),
      .sdio_o               (sdio_o),
      .sdio_oe_o            (sdio_oe_o),
      .serial_data_out_o    (serial_data_out_o),
      .serial_data_out_oe_o (serial_data_out_oe_o),
      .three_wire_i         (three_wire_i),
      .lk                   (lk.link_mp)
   );

   // pins and link toggles, two flip-flops each
   assign sy_in_w = {load_i, protocol_sel_i, cs_n_i, lk.frame_tgl,
                     lk.req_tgl, array_addr_bit3_i, array_addr_bit2_i,
                     array_addr_bit1_i, array_addr_bit0_i};

   always_comb begin
      s1_d = sy_in_w;
      s2_d = s1_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         s1_q <= 9'h000;
         s2_q <= 9'h000;
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end

   // synchronised views and events
   assign straps_w    = s2_q[bfscp_pkg::SY_CHIP_LSB +: 4];
   assign cs_hi_w     = s2_q[bfscp_pkg::SY_CS];
   assign match_w     = (lk.chip == straps_w);
   assign proto_ok_w  = ~s2_q[bfscp_pkg::SY_PROTO];
   assign wr_new_w    = s2_q[bfscp_pkg::SY_FRAME] != frame_seen_q;
   assign commit_w    = wr_new_w & cs_hi_w;
   assign rd_new_w    = s2_q[bfscp_pkg::SY_REQ] != req_seen_q;
   assign load_rise_w = s2_q[bfscp_pkg::SY_LOAD] & ~load_prev_q;
   assign reg_rg_w    = region_of(lk.addr);
   assign wr_txh_w    = commit_w & match_w & proto_ok_w &
                        (reg_rg_w == bfscp_pkg::RG_TXH);

   // status byte: strapped address and pending load rises
   always_comb begin
      status_w = 8'h00;
      status_w[bfscp_pkg::STAT_CHIP_LSB +: 4] = straps_w;
      status_w[bfscp_pkg::STAT_LOAD_LSB +: 2] = load_cnt_q;
   end

   // register file: commits, reads and the load strobe
   always_comb begin
      frame_seen_d = frame_seen_q;
      req_seen_d   = req_seen_q;
      ack_d        = ack_q;
      rd_data_d    = rd_data_q;
      load_prev_d  = s2_q[bfscp_pkg::SY_LOAD];
      load_cnt_d   = load_cnt_q;
      tx_hold_d    = tx_hold_q;
      rx_hold_d    = rx_hold_q;
      tx_work_d    = tx_work_q;
      rx_work_d    = rx_work_q;
      // write commits once chip select is back high
      if (commit_w) begin
         frame_seen_d = s2_q[bfscp_pkg::SY_FRAME];
         if (match_w && proto_ok_w) begin
            case (reg_rg_w)
               bfscp_pkg::RG_TXH: begin
                  tx_hold_d[lk.addr[3:0]] = lk.wdata;
               end
               bfscp_pkg::RG_RXH: begin
                  rx_hold_d[lk.addr[3:0]] = lk.wdata;
               end
               default: begin
               end
            endcase
         end
      end
      // read fetch, answered only when addressed
      if (rd_new_w) begin
         req_seen_d = s2_q[bfscp_pkg::SY_REQ];
         // ack equal to request means answered, opposite means refused
         ack_d      = ~s2_q[bfscp_pkg::SY_REQ];
         if (match_w && proto_ok_w) begin
            ack_d = s2_q[bfscp_pkg::SY_REQ];
            case (reg_rg_w)
               bfscp_pkg::RG_TXH:  rd_data_d = tx_hold_q[lk.addr[3:0]];
               bfscp_pkg::RG_RXH:  rd_data_d = rx_hold_q[lk.addr[3:0]];
               bfscp_pkg::RG_TXW:  rd_data_d = tx_work_q[lk.addr[3:0]];
               bfscp_pkg::RG_RXW:  rd_data_d = rx_work_q[lk.addr[3:0]];
               bfscp_pkg::RG_STAT: rd_data_d = status_w;
               default:            rd_data_d = bfscp_pkg::IDLE_OUT;
            endcase
         end
      end
      // every third load rise moves all channels at once
      if (load_rise_w) begin
         if (load_cnt_q == bfscp_pkg::LOAD_LAST_CNT) begin
            load_cnt_d = 2'h0;
            tx_work_d  = tx_hold_q;
            rx_work_d  = rx_hold_q;
         end else begin
            load_cnt_d = load_cnt_q + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         frame_seen_q <= 1'b0;
         req_seen_q   <= 1'b0;
         ack_q        <= 1'b0;
         rd_data_q    <= bfscp_pkg::REG_RST;
         load_prev_q  <= 1'b0;
         load_cnt_q   <= 2'h0;
         tx_hold_q    <= '0;
         rx_hold_q    <= '0;
         tx_work_q    <= '0;
         rx_work_q    <= '0;
         up_q         <= 1'b0;
      end else begin
         frame_seen_q <= frame_seen_d;
         req_seen_q   <= req_seen_d;
         ack_q        <= ack_d;
         rd_data_q    <= rd_data_d;
         load_prev_q  <= load_prev_d;
         load_cnt_q   <= load_cnt_d;
         tx_hold_q    <= tx_hold_d;
         rx_hold_q    <= rx_hold_d;
         tx_work_q    <= tx_work_d;
         rx_work_q    <= rx_work_d;
         up_q         <= 1'b1;
      end
   end

   // answers back to the link and working outputs
   assign lk.ack_tgl = ack_q;
   assign lk.rd_data = rd_data_q;
   assign tx_work_o  = tx_work_q;
   assign rx_work_o  = rx_work_q;

   property p_rst_clears;
      @(posedge clk_i) disable iff (!arst_n_i)
         !up_q |-> tx_work_q == '0 && rx_work_q == '0 &&
                   load_cnt_q == 2'h0 && !ack_q;
   endproperty
   a_rst_clears: assert property (p_rst_clears)
      else $error("state not cleared by reset");

   property p_addr_gate_read;
      @(posedge clk_i) disable iff (!arst_n_i)
         (rd_new_w && !match_w) |=> ack_q != req_seen_q;
   endproperty
   a_addr_gate_read: assert property (p_addr_gate_read)
      else $error("read answered for a foreign array address");

   property p_third_load;
      @(posedge clk_i) disable iff (!arst_n_i)
         (load_rise_w && load_cnt_q == 2'h2) |=>
            tx_work_q == $past(tx_hold_q) &&
            rx_work_q == $past(rx_hold_q) && load_cnt_q == 2'h0;
   endproperty
   a_third_load: assert property (p_third_load)
      else $error("third load rise did not copy");

   property p_early_load;
      @(posedge clk_i) disable iff (!arst_n_i)
         (load_rise_w && load_cnt_q != 2'h2) |=>
            $stable(tx_work_q) && $stable(rx_work_q) &&
            load_cnt_q == $past(load_cnt_q) + 2'h1;
   endproperty
   a_early_load: assert property (p_early_load)
      else $error("working registers changed before third rise");

   property p_commit_write;
      @(posedge clk_i) disable iff (!arst_n_i)
         wr_txh_w |=> tx_hold_q[$past(lk.addr[3:0])] == $past(lk.wdata);
   endproperty
   a_commit_write: assert property (p_commit_write)
      else $error("write data not committed at chip select rise");

   property p_mismatch_drop;
      @(posedge clk_i) disable iff (!arst_n_i)
         (commit_w && !match_w) |=> $stable(tx_hold_q) &&
                                    $stable(rx_hold_q);
   endproperty
   a_mismatch_drop: assert property (p_mismatch_drop)
      else $error("foreign instruction changed a register");

   property p_cs_low_no_commit;
      @(posedge clk_i) disable iff (!arst_n_i)
         !cs_hi_w |=> $stable(tx_hold_q) && $stable(rx_hold_q);
   endproperty
   a_cs_low_no_commit: assert property (p_cs_low_no_commit)
      else $error("register written while chip select low");

endmodule : beamformer_serial_control_port

/* File: logic/bfscp_pkg.sv */
package bfscp_pkg;

   // frame layout, msb first: rw, array address, register address, data
   localparam int CHIP_BITS = 4;
   localparam int ADDR_BITS = 11;
   localparam int DATA_BITS = 8;
   localparam int CHANNELS  = 16;
   localparam int CNT_BITS  = 6;

   // instruction field positions inside the 16-bit instruction word
   localparam int INSTR_RW_POS   = 15;
   localparam int INSTR_CHIP_LSB = 11;
   localparam int INSTR_ADDR_LSB = 0;

   // bit counter values on the link
   localparam logic [5:0] CNT_INSTR_LAST = 6'h0F;
   localparam logic [5:0] CNT_WDATA_LAST = 6'h17;
   localparam logic [5:0] CNT_RDATA_FIRST = 6'h18;
   localparam logic [5:0] CNT_RDATA_END  = 6'h20;
   localparam logic [5:0] CNT_MAX        = 6'h3F;

   // register map of the serial port
   localparam logic [10:0] TX_HOLD_BASE = 11'h000;
   localparam logic [10:0] RX_HOLD_BASE = 11'h010;
   localparam logic [10:0] TX_WORK_BASE = 11'h020;
   localparam logic [10:0] RX_WORK_BASE = 11'h030;
   localparam logic [10:0] STATUS_ADDR  = 11'h040;

   // status byte fields
   localparam int STAT_CHIP_LSB = 0;
   localparam int STAT_LOAD_LSB = 4;

   // reset values
   localparam logic [7:0] REG_RST  = 8'h00;
   localparam logic [7:0] IDLE_OUT = 8'h00;

   // load strobe: copy happens on the rise seen while the count holds this
   localparam logic [1:0] LOAD_LAST_CNT = 2'h2;

   // positions in the synchroniser vector of the core
   localparam int SY_CHIP_LSB = 0;
   localparam int SY_REQ      = 4;
   localparam int SY_FRAME    = 5;
   localparam int SY_CS       = 6;
   localparam int SY_PROTO    = 7;
   localparam int SY_LOAD     = 8;
   localparam int SY_W        = 9;

   // register regions
   typedef enum logic [2:0] {
      RG_TXH  = 3'b000,
      RG_RXH  = 3'b001,
      RG_TXW  = 3'b010,
      RG_RXW  = 3'b011,
      RG_STAT = 3'b100,
      RG_NONE = 3'b111
   } region_t;

endpackage : bfscp_pkg

/* File: logic/link_if.sv */
`timescale 1ns/1ps
interface link_if;
   logic                               rw;
   logic [bfscp_pkg::CHIP_BITS-1:0]    chip;
   logic [bfscp_pkg::ADDR_BITS-1:0]    addr;
   logic [bfscp_pkg::DATA_BITS-1:0]    wdata;
   logic                               frame_tgl;
   logic                               req_tgl;
   logic                               ack_tgl;
   logic [bfscp_pkg::DATA_BITS-1:0]    rd_data;

   // link end produces commands, core end answers reads
   modport link_mp (
      output rw, chip, addr, wdata, frame_tgl, req_tgl,
      input  ack_tgl, rd_data
   );
   modport core_mp (
      input  rw, chip, addr, wdata, frame_tgl, req_tgl,
      output ack_tgl, rd_data
   );
endinterface : link_if

/* File: logic/serial_link_engine.sv */
`timescale 1ns/1ps
module serial_link_engine (
   // link clock and resets
   input  wire logic sclk_i,
   input  wire logic arst_n_i,
   input  wire logic cs_n_i,
   // data pins
   input  wire logic sdio_i,
   output logic      sdio_o,
   output logic      sdio_oe_o,
   output logic      serial_data_out_o,
   output logic      serial_data_out_oe_o,
   // wiring mode strap
   input  wire logic three_wire_i,
   // towards the core
   link_if.link_mp   lk
);

   logic        frame_rst_n;
   logic [5:0]  cnt_q, cnt_d;
   logic [22:0] sh_q, sh_d;
   logic [15:0] instr_w;
   logic [7:0]  byte_w;
   logic        rw_q, rw_d;
   logic [3:0]  chip_q, chip_d;
   logic [10:0] addr_q, addr_d;
   logic [7:0]  wdata_q, wdata_d;
   logic        frame_q, frame_d;
   logic        req_q, req_d;
   logic        hit_q, hit_d;
   logic        ack_s1_q, ack_s1_d, ack_s2_q, ack_s2_d;
   logic        mode_s1_q, mode_s1_d, mode_s2_q, mode_s2_d;
   logic [7:0]  out_q, out_d;
   logic        drive_q, drive_d;

   // the frame ends with chip select high, even with sclk stopped
   assign frame_rst_n = arst_n_i & ~cs_n_i;
   assign instr_w = {sh_q[14:0], sdio_i};
   assign byte_w  = {sh_q[6:0], sdio_i};

   // bit counter and input shifter
   always_comb begin
      cnt_d = (cnt_q == bfscp_pkg::CNT_MAX) ? cnt_q : cnt_q + 6'h01;
      sh_d  = {sh_q[21:0], sdio_i};  // sampled on the rising edge
   end

   always_ff @(posedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         cnt_q <= 6'h00;
         sh_q  <= 23'h000000;
      end else begin
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
      end
   end

   // captured command words, toggles and synchronisers
   always_comb begin
      rw_d      = rw_q;
      chip_d    = chip_q;
      addr_d    = addr_q;
      wdata_d   = wdata_q;
      frame_d   = frame_q;
      req_d     = req_q;
      hit_d     = hit_q;
      ack_s1_d  = lk.ack_tgl;
      ack_s2_d  = ack_s1_q;
      mode_s1_d = three_wire_i;
      mode_s2_d = mode_s1_q;
      if (cnt_q == bfscp_pkg::CNT_INSTR_LAST) begin
         rw_d   = instr_w[bfscp_pkg::INSTR_RW_POS];
         chip_d = instr_w[bfscp_pkg::INSTR_CHIP_LSB +: 4];
         addr_d = instr_w[bfscp_pkg::INSTR_ADDR_LSB +: 11];
         if (instr_w[bfscp_pkg::INSTR_RW_POS]) begin
            req_d = ~req_q;  // read request to the core
         end
      end
      if (cnt_q == bfscp_pkg::CNT_WDATA_LAST) begin
         hit_d = (ack_s2_q == req_q);  // core answered: address matched
         if (!rw_q) begin
            wdata_d = byte_w;
            frame_d = ~frame_q;  // write complete, waits for cs rise
         end
      end
   end

   always_ff @(posedge sclk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rw_q      <= 1'b0;
         chip_q    <= 4'h0;
         addr_q    <= 11'h000;
         wdata_q   <= 8'h00;
         frame_q   <= 1'b0;
         req_q     <= 1'b0;
         hit_q     <= 1'b0;
         ack_s1_q  <= 1'b0;
         ack_s2_q  <= 1'b0;
         mode_s1_q <= 1'b0;
         mode_s2_q <= 1'b0;
      end else begin
         rw_q      <= rw_d;
         chip_q    <= chip_d;
         addr_q    <= addr_d;
         wdata_q   <= wdata_d;
         frame_q   <= frame_d;
         req_q     <= req_d;
         hit_q     <= hit_d;
         ack_s1_q  <= ack_s1_d;
         ack_s2_q  <= ack_s2_d;
         mode_s1_q <= mode_s1_d;
         mode_s2_q <= mode_s2_d;
      end
   end

   // read shifter, changes on the falling edge
   always_comb begin
      out_d   = {out_q[6:0], 1'b0};
      drive_d = drive_q;
      if (cnt_q == bfscp_pkg::CNT_RDATA_FIRST) begin
         out_d   = hit_q ? lk.rd_data : bfscp_pkg::IDLE_OUT;
         drive_d = rw_q & hit_q;  // only the addressed device drives
      end else if (cnt_q >= bfscp_pkg::CNT_RDATA_END) begin
         drive_d = 1'b0;
      end
   end

   always_ff @(negedge sclk_i or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         out_q   <= bfscp_pkg::IDLE_OUT;
         drive_q <= 1'b0;
      end else begin
         out_q   <= out_d;
         drive_q <= drive_d;
      end
   end

   // pin steering by wiring mode
   assign sdio_o               = out_q[7];
   assign sdio_oe_o            = drive_q & mode_s2_q;
   assign serial_data_out_o    = out_q[7];
   assign serial_data_out_oe_o = drive_q & ~mode_s2_q;

   // command words to the core
   assign lk.rw        = rw_q;
   assign lk.chip      = chip_q;
   assign lk.addr      = addr_q;
   assign lk.wdata     = wdata_q;
   assign lk.frame_tgl = frame_q;
   assign lk.req_tgl   = req_q;

   property p_four_wire_input;
      @(posedge sclk_i) disable iff (!arst_n_i)
         !mode_s2_q |-> !sdio_oe_o;
   endproperty
   a_four_wire_input: assert property (p_four_wire_input)
      else $error("sdio driven in 4-wire mode");

   property p_three_wire_turn;
      @(posedge sclk_i) disable iff (!frame_rst_n)
         (mode_s2_q && rw_q && hit_q && cnt_q == 6'h18)
            |-> sdio_oe_o && !serial_data_out_oe_o;
   endproperty
   a_three_wire_turn: assert property (p_three_wire_turn)
      else $error("sdio not turned around for read data");

   property p_rise_sample;
      @(posedge sclk_i) disable iff (!arst_n_i)
         (cnt_q == bfscp_pkg::CNT_WDATA_LAST && !rw_q)
            |=> wdata_q == $past(byte_w);
   endproperty
   a_rise_sample: assert property (p_rise_sample)
      else $error("write byte not taken on rising edges");

   property p_quiet_deselected;
      @(posedge sclk_i) disable iff (!arst_n_i)
         (cnt_q == 6'h00) |-> !serial_data_out_oe_o && !sdio_oe_o;
   endproperty
   a_quiet_deselected: assert property (p_quiet_deselected)
      else $error("data pin still driven after deselect");

endmodule : serial_link_engine

/* File: test/beamformer_serial_control_port_tb_top.sv */
`timescale 1ns/1ps
module beamformer_serial_control_port_tb_top;
   logic             clk_i    = 1'b0;
   logic             arst_n_i = 1'b0;
   logic [3:0]       straps   = 4'h5;
   logic             psel     = 1'b0;
   logic             three    = 1'b0;
   logic             load     = 1'b0;
   logic             sclk, cs_n, line, io_o, io_oe, dout, dout_oe;
   logic [15:0][7:0] tx_work, rx_work;
   logic [7:0]       rd;
   logic             ok, any;
   int               bad_count = 0;
   int               tests_run = 0;
   int               cycles    = 0;

   // system clock
   always #4 clk_i = ~clk_i;

   beamformer_serial_control_port uut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .sdio_i(line), .sdio_o(io_o), .sdio_oe_o(io_oe),
      .serial_data_out_o(dout), .serial_data_out_oe_o(dout_oe),
      .array_addr_bit0_i(straps[0]), .array_addr_bit1_i(straps[1]),
      .array_addr_bit2_i(straps[2]), .array_addr_bit3_i(straps[3]),
      .protocol_sel_i(psel), .three_wire_i(three), .load_i(load),
      .tx_work_o(tx_work), .rx_work_o(rx_work));

   serial_host_model host (
      .io_i(io_o), .io_oe_i(io_oe), .dout_i(dout), .dout_oe_i(dout_oe),
      .three_i(three), .sclk_o(sclk), .cs_n_o(cs_n), .line_o(line));

   task automatic chk(input string what, input logic [7:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic clks(input int n);
      repeat (n) @(posedge clk_i);
   endtask : clks

   // write frame, then room for the commit to cross
   task automatic wr(input logic [3:0] c, input logic [10:0] a,
                     input logic [7:0] d, input int n);
      host.frame({1'b0, c, a, d, 8'h00}, n, rd, ok, any);
      clks(8);
   endtask : wr

   task automatic rdreg(input logic [3:0] c, input logic [10:0] a);
      host.frame({1'b1, c, a, 16'h0000}, 32, rd, ok, any);
   endtask : rdreg

   // one rise of the load strobe; t_load checks after the second and third
   task automatic pulse;
      load <= 1'b1;
      clks(3);
      load <= 1'b0;
      clks(3);
   endtask : pulse

   task automatic t_reset;
      chk("tx_work0", 8'h00, tx_work[0]);
      chk("rx_work15", 8'h00, rx_work[15]);
      chk("oe", 8'h00, {6'h00, io_oe, dout_oe});
   endtask : t_reset

   task automatic t_four_wire;
      wr(4'h5, 11'h003, 8'hA5, 24);
      rdreg(4'h5, 11'h003);
      chk("rd4", 8'hA5, rd);
      chk("oe4", 8'h01, {7'h00, ok});
      chk("idle_oe", 8'h00, {7'h00, dout_oe});
   endtask : t_four_wire

   task automatic t_three_wire;
      three <= 1'b1;
      clks(2);
      wr(4'h5, 11'h01F, 8'h3C, 24);
      rdreg(4'h5, 11'h01F);
      chk("rd3", 8'h3C, rd);
      chk("oe3", 8'h01, {7'h00, ok});
      three <= 1'b0;
      clks(2);
   endtask : t_three_wire

   task automatic t_foreign;
      wr(4'h6, 11'h003, 8'hFF, 24);
      rdreg(4'h5, 11'h003);
      chk("foreign_wr", 8'hA5, rd);
      rdreg(4'h6, 11'h003);
      chk("foreign_oe", 8'h00, {7'h00, any});
   endtask : t_foreign

   task automatic t_short;
      wr(4'h5, 11'h003, 8'h5A, 20);
      rdreg(4'h5, 11'h003);
      chk("short", 8'hA5, rd);
   endtask : t_short

   task automatic t_load;
      pulse();
      pulse();
      chk("early", 8'h00, tx_work[3]);
      rdreg(4'h5, 11'h040);
      chk("status", 8'h25, rd);
      pulse();
      chk("tx_load", 8'hA5, tx_work[3]);
      chk("rx_load", 8'h3C, rx_work[15]);
      rdreg(4'h5, 11'h023);
      chk("tx_work_rd", 8'hA5, rd);
   endtask : t_load

   task automatic t_mid_reset;
      arst_n_i <= 1'b0;
      clks(3);
      chk("rst_work", 8'h00, tx_work[3]);
      arst_n_i <= 1'b1;
      clks(4);
      rdreg(4'h5, 11'h003);
      chk("rst_hold", 8'h00, rd);
   endtask : t_mid_reset

   // cycle ceiling against hangs
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end

   initial begin
      clks(16);
      t_reset();
      arst_n_i <= 1'b1;
      clks(4);
      t_four_wire();
      t_three_wire();
      t_foreign();
      t_short();
      t_load();
      t_mid_reset();
      complete_run();
   end
endmodule : beamformer_serial_control_port_tb_top

/* File: test/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
   // pins seen from the device
   input  wire logic io_i,
   input  wire logic io_oe_i,
   input  wire logic dout_i,
   input  wire logic dout_oe_i,
   input  wire logic three_i,
   // pins driven towards the device
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      line_o
);
   logic drv_q  = 1'b0;
   logic en_q   = 1'b0;
   logic junk_q = 1'b0;

   // released line keeps toggling so no stale value is read
   always #4 junk_q = ~junk_q;
   assign line_o = io_oe_i ? io_i : (en_q ? drv_q : junk_q);

   // idle: clock stands low, select high
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
   end

   // one frame, msb first; read bits captured on rises 25..32
   task automatic frame(input logic [31:0] w, input int n,
                        output logic [7:0] rd, output logic ok,
                        output logic any);
      rd = 8'h00;
      ok = 1'b1;
      any = 1'b0;
      en_q = 1'b1;
      #1.3 cs_n_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         if (k == 16 && w[31]) begin
            en_q = 1'b0;
         end
         drv_q = w[31-k];
         #6 sclk_o = 1'b1;
         if (k >= 24) begin
            rd[31-k] = three_i ? line_o : dout_i;
            any = any | io_oe_i | dout_oe_i;
            if (three_i ? (io_oe_i !== 1'b1 || dout_oe_i !== 1'b0)
                        : (dout_oe_i !== 1'b1 || io_oe_i !== 1'b0)) begin
               ok = 1'b0;
            end
         end
         #6 sclk_o = 1'b0;
      end
      #10 cs_n_o = 1'b1;
      en_q = 1'b0;
      #40;
   endtask : frame
endmodule : serial_host_model
